// ---- core/msi_pkg.sv ----
package msi_pkg;
    // Register port geometry
    localparam int          ADDR_W         = 4;
    localparam int          DATA_W         = 8;
    localparam int          NUM_SRC        = 7;

    // Register word addresses
    localparam logic [3:0]  ADDR_FLAGS     = 4'h0;
    localparam logic [3:0]  ADDR_FLAG_CLR  = 4'h1;
    localparam logic [3:0]  ADDR_MASK      = 4'h2;
    localparam logic [3:0]  ADDR_EDGE_MODE = 4'h3;
    localparam logic [3:0]  ADDR_CTRL      = 4'h4;
    localparam logic [3:0]  ADDR_ADC_SEL   = 4'h5;
    localparam logic [3:0]  ADDR_FLAG_SET  = 4'h6;

    // Flag and mask bit positions, index equals priority number
    localparam int          BIT_LVD        = 1;
    localparam int          BIT_PIN_A      = 2;
    localparam int          BIT_PIN_B      = 3;
    localparam int          BIT_TMR_H      = 4;
    localparam int          BIT_T16_A      = 5;
    localparam int          BIT_T16_B      = 6;
    localparam int          BIT_ADC        = 7;

    // Control register fields
    localparam int          BIT_IRQ_ALLOW  = 0;
    localparam int          BIT_LV_MODE    = 1;

    // Edge mode fields: pin a in [1:0], pin b in [3:2]
    localparam int          EDGE_LSB_A     = 0;
    localparam int          EDGE_LSB_B     = 2;
    localparam logic [1:0]  EDGE_FALL      = 2'h0;
    localparam logic [1:0]  EDGE_RISE      = 2'h1;
    localparam logic [1:0]  EDGE_NONE      = 2'h2;
    localparam logic [1:0]  EDGE_BOTH      = 2'h3;

    // Reset values
    localparam logic [7:0]  FLAGS_RST      = 8'h00;
    localparam logic [7:0]  MASK_RST       = 8'hff;
    localparam logic [7:0]  EDGE_RST       = 8'h00;
    localparam logic [1:0]  CTRL_RST       = 2'h0;
    localparam logic [1:0]  ADC_SEL_RST    = 2'h0;

    // Vector table: vector = base + 2 * index
    localparam logic [15:0] VEC_BASE       = 16'h0004;
    localparam logic [15:0] VEC_RESET      = 16'h0000;
endpackage

// ---- core/msi_edge_if.sv ----
`timescale 1ns/1ps
// Edge mode in, detected edge event out
interface msi_edge_if;
    logic [1:0] mode;
    logic       hit;

    modport ctrl (output mode, input hit);
    modport det  (input mode, output hit);
endinterface

// ---- core/msi_edge_det.sv ----
`timescale 1ns/1ps
module msi_edge_det (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // External pin
    input  wire logic pin,
    // Mode and event
    msi_edge_if.det   eif
);
    logic       sync1_q, sync2_q, prev_q, hit_q;
    logic       hit_d;
    logic       rise, fall;

    ////////////////////////////////////////////////////////////////////////
    // Edge decode on the synchronised level only
    always_comb begin
        rise  = sync2_q & ~prev_q;
        fall  = ~sync2_q & prev_q;
        unique case (eif.mode)
            msi_pkg::EDGE_FALL: hit_d = fall;
            msi_pkg::EDGE_RISE: hit_d = rise;
            msi_pkg::EDGE_NONE: hit_d = 1'b0;  // Prohibited code, no event
            msi_pkg::EDGE_BOTH: hit_d = rise | fall;
        endcase
    end

    // Two-stage synchroniser, then history and event register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
            hit_q   <= 1'b0;
        end else begin
            sync1_q <= pin;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
            hit_q   <= hit_d;
        end
    end

    assign eif.hit = hit_q;
endmodule

// ---- core/msi_ctrl.sv ----
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module msi_ctrl #(
    parameter int NUM_SRC = msi_pkg::NUM_SRC
) (
    // Clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    // Register port
    input  wire logic [msi_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [msi_pkg::DATA_W-1:0]    reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [msi_pkg::DATA_W-1:0]    reg_rdata,
    // Internal peripheral events, one-cycle pulses; the capture mode inputs are levels
    input  wire logic                          low_voltage_detect,
    input  wire logic                          timer_h_match,
    input  wire logic                          timer16_a_match,
    input  wire logic                          timer16_a_capture_edge,
    input  wire logic                          timer16_a_capture_mode,
    input  wire logic                          timer16_b_match,
    input  wire logic                          timer16_b_capture_edge,
    input  wire logic                          timer16_b_capture_mode,
    input  wire logic                          adc_conv_done,
    input  wire logic                          watchdog_overflow,
    // External interrupt pins, asynchronous
    input  wire logic                          pin_edge_irq_a,
    input  wire logic                          pin_edge_irq_b,
    // CPU core side
    input  wire logic                          cpu_ack,
    input  wire logic                          cpu_reti,
    output logic                               irq_req,
    output logic      [15:0]                   irq_vector,
    output logic                               save_status_pc,
    output logic                               reset_branch,
    output logic      [15:0]                   reset_vector,
    // Power management and misc
    output logic                               standby_release,
    output logic      [1:0]                    adc_channel_select,
    output logic                               low_voltage_mode_bit
);
    localparam int ST_W = $clog2(NUM_SRC + 1);

    logic [NUM_SRC:1] flags_q, flags_d, mask_q, mask_d, src_set;
    logic [7:0]       edge_q, edge_d;
    logic             allow_q, allow_d, lvmode_q, lvmode_d;
    logic [1:0]       adcsel_q, adcsel_d;
    logic [ST_W-1:0]  sel_q, sel_d;
    logic             req_q, req_d, save_q, save_d, rstb_q, rstb_d;
    logic [15:0]      vec_q, vec_d;
    logic [7:0]       rdata_q, rdata_d;
    logic [NUM_SRC:1] accept;
    logic             wr_clr, wr_set;

    msi_edge_if eif_a ();
    msi_edge_if eif_b ();

    ////////////////////////////////////////////////////////////////////////
    // External pin edge detection
    assign eif_a.mode = edge_q[msi_pkg::EDGE_LSB_A +: 2];
    assign eif_b.mode = edge_q[msi_pkg::EDGE_LSB_B +: 2];

    msi_edge_det u_edge_a (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pin     (pin_edge_irq_a),
        .eif     (eif_a)
    );

    msi_edge_det u_edge_b (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pin     (pin_edge_irq_b),
        .eif     (eif_b)
    );

    ////////////////////////////////////////////////////////////////////////
    // Source events mapped onto flag positions
    always_comb begin
        src_set = '0;
        src_set[msi_pkg::BIT_LVD]   = low_voltage_detect & ~lvmode_q;
        src_set[msi_pkg::BIT_PIN_A] = eif_a.hit;
        src_set[msi_pkg::BIT_PIN_B] = eif_b.hit;
        src_set[msi_pkg::BIT_TMR_H] = timer_h_match;
        src_set[msi_pkg::BIT_T16_A] = timer16_a_match
                                    | (timer16_a_capture_mode & timer16_a_capture_edge);
        src_set[msi_pkg::BIT_T16_B] = timer16_b_match
                                    | (timer16_b_capture_mode & timer16_b_capture_edge);
        src_set[msi_pkg::BIT_ADC]   = adc_conv_done;
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes, flag updates and acknowledge
    always_comb begin
        wr_clr   = reg_wr && reg_addr == msi_pkg::ADDR_FLAG_CLR;
        wr_set   = reg_wr && reg_addr == msi_pkg::ADDR_FLAG_SET;
        mask_d   = mask_q;
        edge_d   = edge_q;
        allow_d  = allow_q;
        lvmode_d = lvmode_q;
        adcsel_d = adcsel_q;
        flags_d  = flags_q;
        save_d   = 1'b0;
        if (reg_wr) begin
            unique case (reg_addr)
                msi_pkg::ADDR_MASK:      mask_d = reg_wdata[NUM_SRC:1];
                msi_pkg::ADDR_EDGE_MODE: edge_d = reg_wdata;
                msi_pkg::ADDR_CTRL: begin
                    allow_d  = reg_wdata[msi_pkg::BIT_IRQ_ALLOW];
                    lvmode_d = reg_wdata[msi_pkg::BIT_LV_MODE];
                end
                msi_pkg::ADDR_ADC_SEL:   adcsel_d = reg_wdata[1:0];
                default: ;
            endcase
        end
        // Software clear, done by software before an A/D restart
        if (wr_clr) begin
            flags_d = flags_d & ~reg_wdata[NUM_SRC:1];
        end
        // Acknowledge clears the served flag and global enable
        if (cpu_ack && req_q) begin
            flags_d[sel_q] = 1'b0;
            allow_d        = 1'b0;
            save_d         = 1'b1;
        end
        if (cpu_reti) begin
            allow_d = 1'b1;
        end
        // Hardware set wins over any clear in the same cycle
        flags_d = flags_d | src_set;
        if (wr_set) begin
            flags_d = flags_d | reg_wdata[NUM_SRC:1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fixed-priority arbitration on the next state, so request drops with ack
    always_comb begin
        accept = flags_d & ~mask_d;
        sel_d  = '0;
        req_d  = 1'b0;
        for (int i = NUM_SRC; i >= 1; i--) begin
            if (accept[i]) begin
                sel_d = ST_W'(i);
            end
        end
        if (sel_d != '0 && allow_d) begin
            req_d = 1'b1;
        end
        vec_d  = msi_pkg::VEC_BASE + {15'(sel_d), 1'b0};
        rstb_d = watchdog_overflow | (low_voltage_detect & lvmode_q);
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, valid one cycle after the read strobe
    always_comb begin
        rdata_d = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                msi_pkg::ADDR_FLAGS:     rdata_d = {flags_q, 1'b0};
                msi_pkg::ADDR_MASK:      rdata_d = {mask_q, 1'b1};
                msi_pkg::ADDR_EDGE_MODE: rdata_d = edge_q;
                msi_pkg::ADDR_CTRL:      rdata_d = {6'h00, lvmode_q, allow_q};
                msi_pkg::ADDR_ADC_SEL:   rdata_d = {6'h00, adcsel_q};
                default:                 rdata_d = '0;  // Unmapped and write-only read zero
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flags_q  <= msi_pkg::FLAGS_RST[NUM_SRC:1];
            mask_q   <= msi_pkg::MASK_RST[NUM_SRC:1];
            edge_q   <= msi_pkg::EDGE_RST;
            allow_q  <= msi_pkg::CTRL_RST[msi_pkg::BIT_IRQ_ALLOW];
            lvmode_q <= msi_pkg::CTRL_RST[msi_pkg::BIT_LV_MODE];
            adcsel_q <= msi_pkg::ADC_SEL_RST;
            sel_q    <= '0;
            req_q    <= 1'b0;
            vec_q    <= msi_pkg::VEC_RESET;
            save_q   <= 1'b0;
            rstb_q   <= 1'b0;
            rdata_q  <= '0;
        end else begin
            flags_q  <= flags_d;
            mask_q   <= mask_d;
            edge_q   <= edge_d;
            allow_q  <= allow_d;
            lvmode_q <= lvmode_d;
            adcsel_q <= adcsel_d;
            sel_q    <= sel_d;
            req_q    <= req_d;
            vec_q    <= vec_d;
            save_q   <= save_d;
            rstb_q   <= rstb_d;
            rdata_q  <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs; wake ignores global enable so halted cores still resume
    assign standby_release      = |(flags_q & ~mask_q);
    assign irq_req              = req_q;
    assign irq_vector           = vec_q;
    assign save_status_pc       = save_q;
    assign reset_branch         = rstb_q;
    assign reset_vector         = msi_pkg::VEC_RESET;
    assign reg_rdata            = rdata_q;
    assign adc_channel_select   = adcsel_q;
    assign low_voltage_mode_bit = lvmode_q;
endmodule

// ---- dv/msi_ctrl_checker.sv ----
`timescale 1ns/1ps
module msi_ctrl_checker #(
    parameter int NUM_SRC = 7
) (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // Register port and events
    input wire logic [3:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        low_voltage_detect,
    input wire logic        watchdog_overflow,
    // Core and power side
    input wire logic        cpu_ack,
    input wire logic        irq_req,
    input wire logic [15:0] irq_vector,
    input wire logic        save_status_pc,
    input wire logic        reset_branch,
    input wire logic [15:0] reset_vector,
    input wire logic        standby_release,
    input wire logic [1:0]  adc_channel_select,
    input wire logic        low_voltage_mode_bit
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////
    // Accept handshake, vectors and reset-type branches
    ack_takes_a: assert property (cpu_ack && irq_req |=> save_status_pc && !irq_req)
        else $error("accepted request did not start the push");
    save_cause_a: assert property (save_status_pc |-> $past(cpu_ack && irq_req))
        else $error("push without an accepted request");
    vec_range_a: assert property (irq_req |-> irq_vector >= 16'h0006 && !irq_vector[0]
        && irq_vector <= 16'h0004 + 16'(2 * NUM_SRC)) else $error("vector out of table");
    reset_vec_a: assert property (reset_vector == 16'h0000)
        else $error("reset vector not zero");
    watchdog_branch_a: assert property (watchdog_overflow |=> reset_branch)
        else $error("watchdog event did not branch");
    lvd_branch_a: assert property (low_voltage_detect && low_voltage_mode_bit |=> reset_branch)
        else $error("low voltage reset mode did not branch");
    branch_cause_a: assert property (reset_branch |->
        $past(watchdog_overflow || low_voltage_detect && low_voltage_mode_bit))
        else $error("branch without a reset-type cause");
    standby_a: assert property (irq_req |-> standby_release)
        else $error("request without standby release");
    adc_sel_a: assert property (reg_wr && reg_addr == msi_pkg::ADDR_ADC_SEL
        |=> adc_channel_select == $past(reg_wdata[1:0])) else $error("channel select not taken");
    ack_c: cover property (cpu_ack && irq_req);
    branch_c: cover property (reset_branch);
    held_c: cover property (standby_release && !irq_req);
endmodule

bind msi_ctrl msi_ctrl_checker #(.NUM_SRC(NUM_SRC)) msi_ctrl_checker_inst (.ref_clk, .rst,
    .reg_addr, .reg_wdata, .reg_wr, .low_voltage_detect, .watchdog_overflow, .cpu_ack,
    .irq_req, .irq_vector, .save_status_pc, .reset_branch, .reset_vector, .standby_release,
    .adc_channel_select, .low_voltage_mode_bit);

// ---- dv/msi_cpu_model.sv ----
`timescale 1ns/1ps
module msi_cpu_model (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Behaviour knobs
    input  wire logic        auto_ack,
    input  wire logic [3:0]  lag,
    // Controller side
    input  wire logic        irq_req,
    input  wire logic [15:0] irq_vector,
    input  wire logic        save_status_pc,
    output logic             cpu_ack,
    output logic             cpu_reti
);
    logic [15:0] vec_q;
    logic [3:0]  wait_q;
    logic        busy_q;
    logic [15:0] taken[$];

    // Ack after lag cycles; return only once the push is seen
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cpu_ack  <= 1'b0;
            cpu_reti <= 1'b0;
            busy_q   <= 1'b0;
            wait_q   <= 4'h0;
        end else begin
            cpu_ack  <= 1'b0;
            cpu_reti <= 1'b0;
            if (auto_ack && irq_req && !busy_q) begin
                if (wait_q == lag) begin
                    cpu_ack <= 1'b1;
                    vec_q   <= irq_vector;
                    busy_q  <= 1'b1;
                    wait_q  <= 4'h0;
                end else begin
                    wait_q  <= wait_q + 4'h1;
                end
            end
            if (save_status_pc) begin
                taken.push_back(vec_q);
                cpu_reti <= 1'b1;
                busy_q   <= 1'b0;
            end
        end
    end
endmodule

// ---- dv/msi_ctrl_tb_top.sv ----
`timescale 1ns/1ps
module msi_ctrl_tb_top;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  ev = 8'h00;
    logic [1:0]  cap_mode = 2'h0;
    logic        pin_edge_irq_a = 1'b0;
    logic        pin_edge_irq_b = 1'b0;
    logic        auto_ack = 1'b0;
    logic [7:0]  reg_rdata;
    logic [15:0] irq_vector, reset_vector;
    logic        cpu_ack, cpu_reti, irq_req, save_status_pc, reset_branch;
    logic        standby_release, low_voltage_mode_bit;
    logic [1:0]  adc_channel_select;
    int          n_errors = 0;
    int          checks_done = 0;

    always #4 ref_clk = ~ref_clk;
    msi_ctrl #(.NUM_SRC(7)) msi_ctrl_inst (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .low_voltage_detect(ev[0]), .timer_h_match(ev[1]),
        .timer16_a_match(ev[2]), .timer16_a_capture_edge(ev[3]),
        .timer16_a_capture_mode(cap_mode[0]), .timer16_b_match(ev[4]),
        .timer16_b_capture_edge(ev[5]), .timer16_b_capture_mode(cap_mode[1]),
        .adc_conv_done(ev[6]), .watchdog_overflow(ev[7]), .pin_edge_irq_a, .pin_edge_irq_b,
        .cpu_ack, .cpu_reti, .irq_req, .irq_vector, .save_status_pc, .reset_branch,
        .reset_vector, .standby_release, .adc_channel_select, .low_voltage_mode_bit);
    msi_cpu_model msi_cpu_model_inst (.ref_clk, .rst, .auto_ack, .lag(4'h2), .irq_req,
        .irq_vector, .save_status_pc, .cpu_ack, .cpu_reti);

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            n_errors++;
        end
    endtask
    // Writes settle two edges so outputs are looked at once stable
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    task automatic rc(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), {8'h00, reg_rdata}, {8'h00, e});
    endtask
    task automatic pulse(input int i);
        @(posedge ref_clk);
        ev[i] <= 1'b1;
        @(posedge ref_clk);
        ev[i] <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    task automatic end_of_test();
        if (n_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rc(msi_pkg::ADDR_MASK, 8'hff);
        rc(msi_pkg::ADDR_FLAGS, 8'h00);
        rc(4'hf, 8'h00);
    endtask
    // Each event alone, enable off: flag and standby only
    task automatic t_events();
        int bt[8] = '{1, 4, 5, 5, 6, 6, 7, 0};
        @(posedge ref_clk);
        cap_mode <= 2'h3;
        wr(msi_pkg::ADDR_MASK, 8'h00);
        for (int k = 0; k < 7; k++) begin
            pulse(k);
            rc(msi_pkg::ADDR_FLAGS, 8'h01 << bt[k]);
            chk("standby", {15'h0000, standby_release}, 16'h0001);
            chk("irq_req", {15'h0000, irq_req}, 16'h0000);
            wr(msi_pkg::ADDR_FLAG_CLR, 8'hfe);
        end
        @(posedge ref_clk);
        cap_mode <= 2'h0;
        pulse(3);
        rc(msi_pkg::ADDR_FLAGS, 8'h00);
    endtask
    task automatic t_pins();
        wr(msi_pkg::ADDR_EDGE_MODE, 8'h0d);
        @(posedge ref_clk);
        pin_edge_irq_a <= 1'b1;
        pin_edge_irq_b <= 1'b1;
        repeat (8) @(posedge ref_clk);
        rc(msi_pkg::ADDR_FLAGS, 8'h0c);
        wr(msi_pkg::ADDR_FLAG_CLR, 8'hfe);
        @(posedge ref_clk);
        pin_edge_irq_a <= 1'b0;
        pin_edge_irq_b <= 1'b0;
        repeat (8) @(posedge ref_clk);
        rc(msi_pkg::ADDR_FLAGS, 8'h08);
        wr(msi_pkg::ADDR_FLAG_CLR, 8'hfe);
    endtask
    task automatic t_hold();
        wr(msi_pkg::ADDR_MASK, 8'hff);
        wr(msi_pkg::ADDR_CTRL, 8'h01);
        pulse(1);
        chk("irq_req", {15'h0000, irq_req}, 16'h0000);
        chk("standby", {15'h0000, standby_release}, 16'h0000);
        rc(msi_pkg::ADDR_FLAGS, 8'h10);
        wr(msi_pkg::ADDR_MASK, 8'hef);
        chk("irq_req", {15'h0000, irq_req}, 16'h0001);
        chk("vector", irq_vector, 16'h000c);
        wr(msi_pkg::ADDR_CTRL, 8'h00);
        chk("irq_req", {15'h0000, irq_req}, 16'h0000);
        wr(msi_pkg::ADDR_FLAG_CLR, 8'h10);
    endtask
    // All seven pending at once, served one by one by the core model
    task automatic t_prio();
        wr(msi_pkg::ADDR_MASK, 8'h00);
        wr(msi_pkg::ADDR_FLAG_SET, 8'hfe);
        auto_ack <= 1'b1;
        wr(msi_pkg::ADDR_CTRL, 8'h01);
        for (int k = 0; k < 300 && msi_cpu_model_inst.taken.size() < 7; k++)
            @(posedge ref_clk);
        for (int k = 0; k < 7; k++)
            chk("vector", msi_cpu_model_inst.taken[k], 16'h0006 + 16'(2 * k));
        auto_ack <= 1'b0;
        rc(msi_pkg::ADDR_FLAGS, 8'h00);
    endtask
    task automatic t_adc();
        wr(msi_pkg::ADDR_MASK, 8'hff);
        pulse(6);
        wr(msi_pkg::ADDR_ADC_SEL, 8'h03);
        rc(msi_pkg::ADDR_FLAGS, 8'h80);
        chk("adc sel", {14'h0000, adc_channel_select}, 16'h0003);
        wr(msi_pkg::ADDR_FLAG_CLR, 8'h80);
        rc(msi_pkg::ADDR_FLAGS, 8'h00);
    endtask
    task automatic t_resets();
        wr(msi_pkg::ADDR_CTRL, 8'h02);
        chk("lv mode", {15'h0000, low_voltage_mode_bit}, 16'h0001);
        rc(msi_pkg::ADDR_CTRL, 8'h02);
        pulse(0);
        pulse(7);
        // Branch pulse stands only the cycle after the watchdog event
        @(posedge ref_clk);
        ev[7] <= 1'b1;
        @(posedge ref_clk);
        ev[7] <= 1'b0;
        #1;
        chk("branch", {15'h0000, reset_branch}, 16'h0001);
        chk("reset vec", reset_vector, 16'h0000);
        rc(msi_pkg::ADDR_FLAGS, 8'h00);
    endtask

    // Reset, then each scenario in turn
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_events();
        t_pins();
        t_hold();
        t_prio();
        t_adc();
        t_resets();
        end_of_test();
    end
    // Hang guard, well beyond the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        end_of_test();
    end
endmodule
